/* eipl_pkg.sv */
// constants, types and helpers shared by the priority-low block
package eipl_pkg;

	// ----------------------------------------------------------------
	// register map: printed index, byte address is four times it
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W     = 12;
	localparam logic [9:0]  IDX_EN     = 10'h000;
	localparam logic [9:0]  IDX_STAT   = 10'h001;
	localparam logic [9:0]  IDX_HIGH   = 10'h0F1;
	localparam logic [9:0]  IDX_LOW    = 10'h0F8;

	// ----------------------------------------------------------------
	// field layout and reset values
	// ----------------------------------------------------------------
	localparam int unsigned NSRC       = 6;
	localparam int unsigned PRIO_W     = 5;
	localparam logic [2:0]  RSVD_ONES  = 3'h7;
	localparam logic [4:0]  PRIO_RST   = 5'h00;
	localparam logic [5:0]  EN_RST     = 6'h00;
	localparam logic [2:0]  LVL_PFAIL  = 3'h4;
	localparam logic [2:0]  LVL_NONE   = 3'h0;

	// ----------------------------------------------------------------
	// sources, in natural order (lower code wins a tie)
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SRC_PFAIL = 3'b000,
		SRC_EXT2  = 3'b001,
		SRC_EXT3  = 3'b010,
		SRC_EXT4  = 3'b011,
		SRC_EXT5  = 3'b100,
		SRC_WDOG  = 3'b101
	} eipl_src_t;

	// bus slave states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ANS  = 2'b01
	} eipl_state_t;

	// level from a high/low bit pair: 0 natural .. 3 highest
	function automatic logic [2:0] pair_level(input logic hi, input logic lo);
		pair_level = {1'b0, hi, lo};
	endfunction : pair_level

	// word index of a byte address, aligned accesses only
	function automatic logic [9:0] word_idx(input logic [ADDR_W-1:0] a);
		word_idx = a[ADDR_W-1:2];
	endfunction : word_idx

endpackage : eipl_pkg

/* eipl_arb_if.sv */
// bundle between the register block and the level arbiter
`timescale 1ns/10ps
interface eipl_arb_if;
	import eipl_pkg::*;
	logic [NSRC-1:0]   req;
	logic [3*NSRC-1:0] lvl;
	logic              valid;
	eipl_src_t         src;
	logic [2:0]        level;
	modport regs (output req, lvl, input valid, src, level);
	modport arb  (input req, lvl, output valid, src, level);
endinterface : eipl_arb_if

/* eipl_sync.sv */
// two-stage synchroniser for a vector of pin levels
`timescale 1ns/10ps
module eipl_sync #(
	parameter int unsigned W = 6
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// levels
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q;
	logic [W-1:0] sync_d;

	// first stage feeds only the second
	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;

endmodule : eipl_sync

/* eipl_arbiter.sv */
// picks the pending source with the highest level
`timescale 1ns/10ps
module eipl_arbiter
	import eipl_pkg::*;
(
	eipl_arb_if.arb bus
);

	// ----------------------------------------------------------------
	// scan from the last source down, so a tie goes to the lower code
	// ----------------------------------------------------------------
	always_comb begin
		logic [2:0] best;
		logic [2:0] cur;
		logic       any;
		eipl_src_t  pick;
		best = LVL_NONE;
		cur  = LVL_NONE;
		any  = 1'b0;
		pick = SRC_PFAIL;
		for (int i = NSRC - 1; i >= 0; i--) begin
			cur = bus.lvl[3*i +: 3];
			if (bus.req[i] && (!any || cur >= best)) begin
				best = cur;
				any  = 1'b1;
				pick = eipl_src_t'(3'(i));
			end
		end
		bus.valid = any;
		bus.src   = pick;
		bus.level = best;
	end

endmodule : eipl_arbiter

/* eipl_top.sv */
// priority-low register pair, enables and level arbiter on APB
`timescale 1ns/10ps
module eipl_top
	import eipl_pkg::*;
(
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// request pins, active high levels
	input  wire logic              pfail_irq_req,
	input  wire logic [3:0]        ext_irq_req,
	input  wire logic              wdog_irq_req,
	// service request towards the cpu
	output logic                   irq_valid,
	output logic      [2:0]        irq_src,
	output logic      [2:0]        irq_level
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	eipl_state_t       st_q;
	eipl_state_t       st_d;
	logic [PRIO_W-1:0] prio_low_q;
	logic [PRIO_W-1:0] prio_low_d;
	logic [PRIO_W-1:0] prio_high_q;
	logic [PRIO_W-1:0] prio_high_d;
	logic [NSRC-1:0]   en_q;
	logic [NSRC-1:0]   en_d;
	logic [31:0]       prdata_q;
	logic [31:0]       prdata_d;
	logic              pready_q;
	logic              pready_d;
	logic              pslverr_q;
	logic              pslverr_d;
	logic              irq_valid_q;
	logic              irq_valid_d;
	logic [2:0]        irq_src_q;
	logic [2:0]        irq_src_d;
	logic [2:0]        irq_level_q;
	logic [2:0]        irq_level_d;

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	logic [NSRC-1:0] raw_req;
	logic [NSRC-1:0] sync_req;
	logic [NSRC-1:0] pend;
	logic [9:0]      idx;
	logic            aligned;
	logic            hit;
	logic            wr_fire;
	logic [31:0]     rd_word;
	logic [31:0]     stat_word;

	eipl_arb_if arb_bus ();

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	// all request pins are asynchronous to pclk
	// bit i of every request vector is source code i, power-fail first
	assign raw_req = {wdog_irq_req, ext_irq_req, pfail_irq_req};

	eipl_sync #(
		.W        (NSRC)
	) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (raw_req),
		.sync_out (sync_req)
	);

	// ----------------------------------------------------------------
	// enable gating and level encoding
	// ----------------------------------------------------------------
	// a disabled source never reaches the arbiter
	// gating after the sync keeps an enable write from meeting a half-settled pin
	assign pend = sync_req & en_q;

	always_comb begin
		arb_bus.req = pend;
		arb_bus.lvl[3*SRC_PFAIL +: 3] = LVL_PFAIL;
		// each pair: high bit from the companion, low bit from this one
		for (int i = 1; i < NSRC; i++) begin
			arb_bus.lvl[3*i +: 3] = pair_level(prio_high_q[i-1], prio_low_q[i-1]);
		end
	end

	// purely combinational pick; the winner registers below give it a full cycle
	eipl_arbiter u_arb (
		.bus (arb_bus.arb)
	);

	// ----------------------------------------------------------------
	// apb address decode
	// ----------------------------------------------------------------
	// byte address is the printed index times four
	assign idx     = word_idx(paddr);
	assign aligned = (paddr[1:0] == 2'b00);
	assign hit     = aligned && ((idx == IDX_LOW) || (idx == IDX_HIGH) ||
	                 (idx == IDX_EN) || (idx == IDX_STAT));

	// write lands only on the completing edge of the access phase
	// a refused address or a cleared lane-zero strobe leaves every bit alone
	assign wr_fire = (st_q == ST_ANS) && psel && penable && pwrite &&
	                 !pslverr_q && pstrb[0];

	// ----------------------------------------------------------------
	// status view
	// ----------------------------------------------------------------
	// built from registered winner fields so a read never sees a half-updated pick
	always_comb begin
		stat_word        = 32'h0000_0000;
		stat_word[5:0]   = pend;
		stat_word[8]     = irq_valid_q;
		stat_word[14:12] = irq_src_q;
		stat_word[18:16] = irq_level_q;
	end

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	always_comb begin
		rd_word = 32'h0000_0000;
		case (idx)
			IDX_LOW: begin
				// reserved bits are forced ones, never stored, so no write reaches them
				rd_word[7:0] = {RSVD_ONES, prio_low_q};
			end
			IDX_HIGH: begin
				rd_word[7:0] = {RSVD_ONES, prio_high_q};
			end
			IDX_EN: begin
				rd_word[NSRC-1:0] = en_q;
			end
			IDX_STAT: begin
				rd_word = stat_word;
			end
			default: begin
				rd_word = 32'h0000_0000;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// bus slave next state
	// ----------------------------------------------------------------
	// answer registered during setup keeps pready and prdata off the decode path, with no wait cycle
	always_comb begin
		st_d      = st_q;
		pready_d  = 1'b0;
		pslverr_d = 1'b0;
		prdata_d  = prdata_q;
		case (st_q)
			ST_IDLE: begin
				// prdata is frozen at setup; the access cycle only presents it
				if (psel && !penable) begin
					st_d      = ST_ANS;
					pready_d  = 1'b1;
					pslverr_d = !hit;
					prdata_d  = (hit && !pwrite) ? rd_word : 32'h0000_0000;
				end
			end
			ST_ANS: begin
				// pready was high this cycle, the transfer ends here
				st_d = ST_IDLE;
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// bus slave flops
	// ----------------------------------------------------------------
	// answer registers clear so nothing stale shows after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q      <= ST_IDLE;
			prdata_q  <= 32'h0000_0000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			st_q      <= st_d;
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// ----------------------------------------------------------------
	// register file next values
	// ----------------------------------------------------------------
	always_comb begin
		prio_low_d  = prio_low_q;
		prio_high_d = prio_high_q;
		en_d        = en_q;
		if (wr_fire) begin
			case (idx)
				IDX_LOW: begin
					// bits 7 to 5 of the write are dropped
					prio_low_d[4] = pwdata[4];
					prio_low_d[3] = pwdata[3];
					prio_low_d[2] = pwdata[2];
					prio_low_d[1] = pwdata[1];
					prio_low_d[0] = pwdata[0];
				end
				IDX_HIGH: begin
					// companion bits pair position for position with the low ones
					prio_high_d[4] = pwdata[4];
					prio_high_d[3] = pwdata[3];
					prio_high_d[2] = pwdata[2];
					prio_high_d[1] = pwdata[1];
					prio_high_d[0] = pwdata[0];
				end
				IDX_EN: begin
					en_d = pwdata[NSRC-1:0];
				end
				default: begin
					en_d = en_q;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// register file flops
	// ----------------------------------------------------------------
	// every priority bit starts at level 0, every source disabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prio_low_q  <= PRIO_RST;
			prio_high_q <= PRIO_RST;
			en_q        <= EN_RST;
		end else begin
			prio_low_q  <= prio_low_d;
			prio_high_q <= prio_high_d;
			en_q        <= en_d;
		end
	end

	// ----------------------------------------------------------------
	// service request next values
	// ----------------------------------------------------------------
	// winner is re-evaluated every cycle, so a level change takes one edge
	always_comb begin
		irq_valid_d = arb_bus.valid;
		irq_src_d   = arb_bus.valid ? arb_bus.src : SRC_PFAIL;
		irq_level_d = arb_bus.valid ? arb_bus.level : LVL_NONE;
	end

	// ----------------------------------------------------------------
	// service request flops
	// ----------------------------------------------------------------
	// a cleared winner reads as source 0 at level 0
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_valid_q <= 1'b0;
			irq_src_q   <= SRC_PFAIL;
			irq_level_q <= LVL_NONE;
		end else begin
			irq_valid_q <= irq_valid_d;
			irq_src_q   <= irq_src_d;
			irq_level_q <= irq_level_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all straight from flip-flops
	// ----------------------------------------------------------------
	assign prdata    = prdata_q;
	assign pready    = pready_q;
	assign pslverr   = pslverr_q;
	assign irq_valid = irq_valid_q;
	assign irq_src   = irq_src_q;
	assign irq_level = irq_level_q;

endmodule : eipl_top

/* eipl_top_assertions.sv */
// concurrent checks on the ports of the priority-low block
`timescale 1ns/10ps
module eipl_top_chk
	import eipl_pkg::*;
(
	// clock and reset
	input wire logic              pclk,
	input wire logic              presetn,
	// apb
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	// service request
	input wire logic              irq_valid,
	input wire logic [2:0]        irq_src,
	input wire logic [2:0]        irq_level
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ----
	// bus answers
	// ----
	answer_time_a: assert property (psel && !penable && !pready |=> pready)
		else $error("no answer one cycle after setup");
	one_cycle_a: assert property (pready |=> !pready)
		else $error("answer held too long");
	in_access_a: assert property (pready |-> psel && penable && $past(psel && !penable))
		else $error("answer outside an access cycle");
	low_ones_a: assert property (pready && !pwrite && paddr == 12'h3E0 |-> prdata[31:5] == 27'h000_0007)
		else $error("low register upper bits wrong");
	high_ones_a: assert property (pready && !pwrite && paddr == 12'h3C4 |-> prdata[31:5] == 27'h000_0007)
		else $error("high register upper bits wrong");
	map_ok_a: assert property (pready && (paddr == 12'h3E0 || paddr == 12'h3C4) |-> !pslverr)
		else $error("priority register refused");
	err_quiet_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
		else $error("error answer malformed");

	// ----
	// winner outputs
	// ----
	pair_range_a: assert property (irq_valid && irq_src != 3'h0 |-> irq_level <= 3'h3)
		else $error("pair level above three");
	pfail_top_a: assert property ((irq_level == 3'h4) == (irq_valid && irq_src == 3'h0))
		else $error("power-fail level not four");
	idle_zero_a: assert property (!irq_valid |-> irq_src == 3'h0 && irq_level == 3'h0)
		else $error("winner shown while idle");

	// main scenarios reached
	cover property (pready && pslverr);
	cover property (irq_valid && irq_level == 3'h4);
	cover property (pready && pwrite && paddr == 12'h3E0);
endmodule : eipl_top_chk

bind eipl_top eipl_top_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.irq_valid(irq_valid), .irq_src(irq_src), .irq_level(irq_level));

/* tb.sv */
// self-checking bench for the priority-low register block
`timescale 1ns/10ps
module tb
	import eipl_pkg::*;
;
	logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata, seed;
	logic [3:0]        pstrb, ext_irq_req;
	logic              pfail_irq_req, wdog_irq_req, irq_valid;
	logic [2:0]        irq_src, irq_level;
	logic [33:0]       note;
	logic [33:0]       exp_q [$];
	logic [28:0]       tab [12];
	int                n_mismatch = 0;
	int                checks_done = 0;

	eipl_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pfail_irq_req(pfail_irq_req), .ext_irq_req(ext_irq_req),
		.wdog_irq_req(wdog_irq_req), .irq_valid(irq_valid), .irq_src(irq_src), .irq_level(irq_level));

	// ----
	// helpers
	// ----
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task automatic cmp_val(input string what, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask : cmp_val

	task automatic cmp_irq(input logic [6:0] e);
		cmp_val("irq", {25'h000_0000, e}, {25'h000_0000, irq_valid, irq_src, irq_level});
	endtask : cmp_irq

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		xs = t ^ (t << 5);
	endfunction : xs

	// one transfer; request held until pready is seen, answer noted for the monitor
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e,
		input logic err);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		exp_q.push_back({~w, err, e});
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'h0000_0000, 1'b0);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000, e, 1'b0);
	endtask : rd

	// program enables and pairs, raise requests, then look at the winner
	task automatic row(input logic [28:0] r);
		wr(12'h000, {26'h000_0000, r[28:23]});
		wr(12'h3C4, {27'h000_0000, r[22:18]});
		wr(12'h3E0, {27'h000_0000, r[17:13]});
		{wdog_irq_req, ext_irq_req, pfail_irq_req} <= r[12:7];
		repeat (5) @(posedge pclk); // sync path is three edges, two spare
		cmp_irq(r[6:0]);
		rd(12'h000, {26'h000_0000, r[28:23]});
		rd(12'h3C4, {24'h00_0000, 3'h7, r[22:18]});
		rd(12'h004, {13'h0000, r[2:0], 1'b0, r[5:3], 3'h0, r[6], 2'h0, r[28:23] & r[12:7]});
	endtask : row

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_of_test

	// monitor: every completed transfer takes the oldest note
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1) begin
			note = exp_q.pop_front();
			cmp_val("pslverr", {31'h0000_0000, note[32]}, {31'h0000_0000, pslverr});
			if (note[33]) cmp_val("prdata", note[31:0], prdata);
		end
	end

	// watchdog, far beyond the few hundred cycles the sequence needs
	initial begin
		repeat (20000) @(posedge pclk);
		n_mismatch++;
		end_of_test();
	end

	// ----
	// main sequence
	// ----
	initial begin
		{presetn, psel, penable, pwrite, pfail_irq_req, wdog_irq_req} = 6'h00;
		{paddr, pwdata, ext_irq_req} = '0;
		pstrb = 4'hF;
		seed = 32'h0000_001B;
		// rows: enables, high pairs, low pairs, requests, expected valid/src/level
		tab = '{{6'h3F, 5'h00, 5'h00, 6'h02, 7'h48}, {6'h3F, 5'h00, 5'h01, 6'h02, 7'h49},
			{6'h3F, 5'h01, 5'h00, 6'h02, 7'h4A}, {6'h3F, 5'h01, 5'h01, 6'h02, 7'h4B},
			{6'h3F, 5'h02, 5'h02, 6'h06, 7'h53}, {6'h3F, 5'h04, 5'h00, 6'h0A, 7'h5A},
			{6'h3F, 5'h00, 5'h08, 6'h12, 7'h61}, {6'h3F, 5'h00, 5'h10, 6'h22, 7'h69},
			{6'h3F, 5'h10, 5'h08, 6'h30, 7'h6A}, {6'h3F, 5'h10, 5'h08, 6'h31, 7'h44},
			{6'h1E, 5'h1F, 5'h1F, 6'h3F, 7'h4B}, {6'h00, 5'h1F, 5'h1F, 6'h3F, 7'h00}};
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(12'h3E0, 32'h0000_00E0);
		rd(12'h3C4, 32'h0000_00E0);
		for (int i = 0; i < 5; i++) begin
			wr(12'h3E0, 32'h0000_0001 << i);
			rd(12'h3E0, 32'h0000_00E0 | (32'h0000_0001 << i));
		end
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			wr(12'h3E0, seed);
			rd(12'h3E0, {24'h00_0000, 3'h7, seed[4:0]});
		end
		pstrb <= 4'hE; // lane zero off, write must not land
		wr(12'h3E0, ~seed);
		pstrb <= 4'hF;
		apb(1'b0, 12'h008, 32'h0000_0000, 32'h0000_0000, 1'b1);
		apb(1'b1, 12'h3E2, ~seed, 32'h0000_0000, 1'b1);
		rd(12'h3E0, {24'h00_0000, 3'h7, seed[4:0]});
		foreach (tab[k]) row(tab[k]);
		presetn <= 1'b0; // mid-run reset must clear the stored pairs
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(12'h3E0, 32'h0000_00E0);
		rd(12'h3C4, 32'h0000_00E0);
		repeat (4) @(posedge pclk);
		cmp_val("notes left", 32'h0000_0000, 32'(exp_q.size()));
		end_of_test();
	end
endmodule : tb
